// *** design/down_event_counter.sv ***
// down event counter: counts qualified input edges, flags the target
// assumes all inputs are synchronous to clk; reset stands for power-up
// Function
// R01: down mode decrements count by one per qualifying count edge, from load
// R02: terminal flag is on when the count equals the target
// R03: qualifying reload edge loads the count and clears the flag; without latching the code sets the flag when load equals target
// R04: target value is programmable from 0 to 9999
// R05: load value 0..9999, copied at power-up and every reload
// R06: latching keeps the flag on after target until reload
// R07: without latching the flag follows count equals target only
// R08: edge selection both counts rising and falling edges
// R09: edge selection high counts rising edges only
// R10: edge selection low counts falling edges only
// R11: reload on rising or falling reload edge per reload selection
// R12: current count 0..9999 is readable as status
// R13: incrementing from 9999 wraps to zero
// R14: count input error freezes counting, reloads still work
// R15: reload input error blocks reloads, counting still works
// R16: flag derives only from count and target, never error
// R17: no error is generated or passed on by the block
// R18: decrementing from zero wraps to 9999
// R19: inputs sampled on clk, edges found by compare; reload beats count
`timescale 1ns/1ps
`default_nettype none
module down_event_counter
  import down_event_counter_pkg::*;
(
  input  wire logic                                 clk,           // system clock
  input  wire logic                                 reset_n,       // async reset, low
  input  wire logic                                 countPulseIn,  // count input
  input  wire logic                                 countErr,      // count input error
  input  wire logic                                 reloadIn,      // reload input
  input  wire logic                                 reloadErr,     // reload input error
  input  wire down_event_counter_pkg::count_dir_t   countDir,      // up or down
  input  wire down_event_counter_pkg::count_edge_t  countEdge,     // counted edges
  input  wire down_event_counter_pkg::reload_edge_t reloadEdge,    // reload edge
  input  wire logic                                 latchEn,       // latch the flag
  input  wire logic [13:0]                          targetValue,   // target 0..9999
  input  wire logic [13:0]                          loadValue,     // load 0..9999
  output logic [13:0]                               countValue,    // current count
  output logic                                      termFlag,      // count hit target
  output logic                                      errOut         // always low
);
  import down_event_counter_pkg::*;

  logic        errOut_r;
  logic [13:0] count_nxt;
  logic        loaded_r;
  logic        cntRise;
  logic        cntFall;
  logic        rldRise;
  logic        rldFall;
  logic        countHit;
  logic        reloadHit;
  logic [13:0] stepped;
  logic [13:0] countVal_r;
  logic [13:0] loadClamp;
  logic [13:0] targetClamp;
  logic        flag_r;
  logic        flag_nxt;

  edge_qualifier u_cnt_edge (
    .clk      (clk),
    .reset_n  (reset_n),
    .sigIn    (countPulseIn),
    .riseSeen (cntRise),
    .fallSeen (cntFall)
  );

  edge_qualifier u_rld_edge (
    .clk      (clk),
    .reset_n  (reset_n),
    .sigIn    (reloadIn),
    .riseSeen (rldRise),
    .fallSeen (rldFall)
  );

  count_wrap u_wrap (
    .countIn  (countVal_r),
    .goDown   (countDir == DIR_DOWN),
    .countOut (stepped)
  );

  // out-of-range settings are held at the top of range
  assign loadClamp   = (loadValue > COUNT_MAX) ? COUNT_MAX : loadValue;      // see R05
  assign targetClamp = (targetValue > COUNT_MAX) ? COUNT_MAX : targetValue;  // see R04

  always_comb begin
    countHit = 1'b0;
    unique case (countEdge)
      EDGE_BOTH: countHit = cntRise | cntFall;  // see R08
      EDGE_RISE: countHit = cntRise;            // see R09
      EDGE_FALL: countHit = cntFall;            // see R10
      default:   countHit = 1'b0;
    endcase
    countHit = countHit & ~countErr;            // see R14
  end

  always_comb begin
    if (reloadEdge == RELOAD_RISE) begin
      reloadHit = rldRise;                      // see R11
    end else begin
      reloadHit = rldFall;                      // see R11
    end
    reloadHit = reloadHit & ~reloadErr;         // see R15
  end

  // first cycle after reset copies the load value in
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      loaded_r <= 1'b0;
    end else begin
      loaded_r <= 1'b1;
    end
  end

  always_comb begin
    count_nxt = countVal_r;
    if (!loaded_r || reloadHit) begin
      count_nxt = loadClamp;                    // see R03 see R05 see R19
    end else if (countHit) begin
      count_nxt = stepped;                      // see R01 see R13 see R18
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      countVal_r <= COUNT_ZERO;
    end else begin
      countVal_r <= count_nxt;
    end
  end

  // flag follows the next count so it leaves the flop with the count
  always_comb begin
    if (!loaded_r || reloadHit) begin
      flag_nxt = 1'b0;                                      // see R03
      if (!latchEn) begin
        flag_nxt = (count_nxt == targetClamp);              // see R07
      end
    end else if (latchEn) begin
      flag_nxt = flag_r | (count_nxt == targetClamp);       // see R06
    end else begin
      flag_nxt = (count_nxt == targetClamp);                // see R02 see R07 see R16
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // the block never raises an error; held in a flop like every other output
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      errOut_r <= 1'b0;
    end else begin
      errOut_r <= 1'b0;                         // see R17
    end
  end

  assign countValue = countVal_r;               // see R12
  assign termFlag   = flag_r;
  assign errOut     = errOut_r;
endmodule
`default_nettype wire

// *** design/down_event_counter_pkg.sv ***
// constants and types shared by the down event counter
// assumes a 10 MHz system clock and decimal counts 0..9999
package down_event_counter_pkg;
  localparam int          COUNT_W   = 14;
  localparam logic [13:0] COUNT_MAX = 14'h270F;
  localparam logic [13:0] COUNT_ZERO = 14'h0000;
  localparam logic [13:0] COUNT_ONE = 14'h0001;
  localparam int          CLK_HZ    = 10000000;

  typedef enum logic [1:0] {
    EDGE_BOTH,
    EDGE_RISE,
    EDGE_FALL
  } count_edge_t;

  typedef enum logic {
    DIR_UP,
    DIR_DOWN
  } count_dir_t;

  typedef enum logic {
    RELOAD_RISE,
    RELOAD_FALL
  } reload_edge_t;
endpackage

// *** design/edge_qualifier.sv ***
// qualifies transitions of one sampled digital signal
// assumes the input is synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module edge_qualifier (
  input  wire logic clk,         // system clock
  input  wire logic reset_n,     // async reset, active low
  input  wire logic sigIn,       // sampled signal
  output logic      riseSeen,    // combinational: rose this cycle
  output logic      fallSeen     // combinational: fell this cycle
);
  logic prev_r;

  // previous sample; reset to the current level is impossible, so start low
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= sigIn;
    end
  end

  assign riseSeen = sigIn & ~prev_r;  // see R19
  assign fallSeen = ~sigIn & prev_r;  // see R19
endmodule
`default_nettype wire

// *** design/count_wrap.sv ***
// modulo-10000 step of a count value
// assumes the input count is within 0..9999
`timescale 1ns/1ps
`default_nettype none
module count_wrap
  import down_event_counter_pkg::*;
(
  input  wire logic [13:0] countIn,   // present count
  input  wire logic        goDown,    // 1 decrements, 0 increments
  output logic      [13:0] countOut   // stepped count
);
  always_comb begin
    if (goDown) begin
      if (countIn == COUNT_ZERO) begin
        countOut = COUNT_MAX;                // see R18
      end else begin
        countOut = countIn - COUNT_ONE;      // see R01
      end
    end else begin
      if (countIn >= COUNT_MAX) begin
        countOut = COUNT_ZERO;               // see R13
      end else begin
        countOut = countIn + COUNT_ONE;
      end
    end
  end
endmodule
`default_nettype wire

// *** bench/down_event_counter_sva.sv ***
// port assertions for the down event counter
// assumes it is bound to every counter instance
`timescale 1ns/1ps
`default_nettype none
module down_event_counter_sva
  import down_event_counter_pkg::*;
(
  input wire logic                                 clk,          // clock
  input wire logic                                 reset_n,      // reset
  input wire logic                                 countPulseIn, // count
  input wire logic                                 countErr,     // error
  input wire logic                                 reloadIn,     // reload
  input wire logic                                 reloadErr,    // error
  input wire down_event_counter_pkg::count_dir_t   countDir,     // mode
  input wire down_event_counter_pkg::count_edge_t  countEdge,    // edge
  input wire down_event_counter_pkg::reload_edge_t reloadEdge,   // edge
  input wire logic                                 latchEn,      // latch
  input wire logic [13:0]                          targetValue,  // target
  input wire logic [13:0]                          loadValue,    // load
  input wire logic [13:0]                          countValue,   // count
  input wire logic                                 termFlag,     // flag
  input wire logic                                 errOut        // error
);
  import down_event_counter_pkg::*;
  logic prevC_r, prevR_r, started_r, cntEv, rldEv;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prevC_r <= 1'b0;
      prevR_r <= 1'b0;
      started_r <= 1'b0;
    end else begin
      prevC_r <= countPulseIn;
      prevR_r <= reloadIn;
      started_r <= 1'b1;
    end
  end
  assign cntEv = !countErr && (countEdge == EDGE_BOTH ? countPulseIn != prevC_r :
    countEdge == EDGE_RISE ? countPulseIn && !prevC_r :
    countEdge == EDGE_FALL && !countPulseIn && prevC_r);
  assign rldEv = !reloadErr && (reloadEdge == RELOAD_RISE ? reloadIn && !prevR_r :
    !reloadIn && prevR_r);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_step;
    cntEv && !rldEv && started_r;
  endsequence
  AST_ERR: assert property (!errOut)
    else $error("error output raised");
  AST_RANGE: assert property (countValue <= COUNT_MAX)
    else $error("count out of range");
  AST_LOAD: assert property (rldEv |=> countValue ==
    (($past(loadValue) > COUNT_MAX) ? COUNT_MAX : $past(loadValue)) &&
    !(termFlag && $past(latchEn))) else $error("reload missed");
  AST_DOWN: assert property (s_step ##0 countDir == DIR_DOWN |=> countValue ==
    ($past(countValue) == COUNT_ZERO ? COUNT_MAX : $past(countValue) - COUNT_ONE))
    else $error("bad decrement");
  AST_UP: assert property (s_step ##0 countDir == DIR_UP |=> countValue ==
    ($past(countValue) == COUNT_MAX ? COUNT_ZERO : $past(countValue) + COUNT_ONE))
    else $error("bad increment");
  AST_HOLD: assert property (!cntEv && !rldEv && started_r |=> $stable(countValue))
    else $error("count moved");
  AST_TRACK: assert property (!latchEn && !$past(latchEn) && started_r |->
    termFlag == (countValue ==
    (($past(targetValue) > COUNT_MAX) ? COUNT_MAX : $past(targetValue))))
    else $error("flag wrong");
  AST_LATCH: assert property (latchEn && termFlag && !rldEv |=> termFlag)
    else $error("latched flag lost");
endmodule
bind down_event_counter down_event_counter_sva u_sva (.clk, .reset_n, .countPulseIn,
  .countErr, .reloadIn, .reloadErr, .countDir, .countEdge, .reloadEdge, .latchEn,
  .targetValue, .loadValue, .countValue, .termFlag, .errOut);
`default_nettype wire

// *** bench/count_source.sv ***
// upstream model driving count and reload levels and error flags
// assumes the bench calls its tasks; changes land 1 ns after clk rises
`timescale 1ns/1ps
`default_nettype none
module count_source (
  input  wire logic clk,          // clock
  output var  logic countPulseIn, // count level
  output var  logic reloadIn,     // reload level
  output var  logic countErr,     // count error
  output var  logic reloadErr     // reload error
);
  initial begin
    countPulseIn = 1'b0;
    reloadIn = 1'b0;
    countErr = 1'b0;
    reloadErr = 1'b0;
  end
  task automatic tc(input int n);
    repeat (n) begin
      @(posedge clk);
      #1 countPulseIn = ~countPulseIn;
    end
  endtask
  task automatic tr(input int n);
    repeat (n) begin
      @(posedge clk);
      #1 reloadIn = ~reloadIn;
    end
  endtask
  task automatic err(input logic c, input logic r);
    @(posedge clk);
    #1 countErr = c;
    reloadErr = r;
  endtask
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench for the down event counter
// assumes the source model and checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import down_event_counter_pkg::*;
  logic         clk, reset_n, latchEn, countPulseIn, reloadIn, countErr, reloadErr;
  count_dir_t   countDir;
  count_edge_t  countEdge;
  reload_edge_t reloadEdge;
  logic [13:0]  countValue, targetValue, loadValue;
  logic         termFlag, errOut;
  int           num_errors = 0, n_compared = 0, cyc = 0;
  count_source u_src (.clk, .countPulseIn, .reloadIn, .countErr, .reloadErr);
  down_event_counter u_dut (.clk, .reset_n, .countPulseIn, .countErr, .reloadIn,
    .reloadErr, .countDir, .countEdge, .reloadEdge, .latchEn, .targetValue,
    .loadValue, .countValue, .termFlag, .errOut);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 400) begin
      num_errors++;
      conclude();
    end
  end
  task automatic cmp(input string nm, input logic [13:0] e, input logic [13:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ck(input string t, input logic [13:0] c, input logic f);
    @(posedge clk);
    #1;
    cmp("count", c, countValue);
    cmp("flag", {13'h0000, f}, {13'h0000, termFlag});
    cmp("err", 14'h0000, {13'h0000, errOut});
    $display("test %s done", t);
  endtask
  task automatic conclude();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    reset_n = 1'b0;
    latchEn = 1'b0;
    targetValue = 14'h0003;
    loadValue = 14'h0005;
    countDir = DIR_DOWN;
    countEdge = EDGE_RISE;
    reloadEdge = RELOAD_RISE;
    repeat (16) @(posedge clk);
    #1 reset_n = 1'b1;
    ck("load", 14'h0005, 1'b0);
    u_src.tc(4);
    ck("rise", 14'h0003, 1'b1);
    countEdge = EDGE_FALL;
    u_src.tc(2);
    ck("fall", 14'h0002, 1'b0);
    countEdge = EDGE_BOTH;
    u_src.tc(2);
    ck("both", 14'h0000, 1'b0);
    u_src.tc(1);
    ck("wrapdn", 14'h270F, 1'b0);
    countDir = DIR_UP;
    u_src.tc(1);
    ck("wrapup", 14'h0000, 1'b0);
    countDir = DIR_DOWN;
    u_src.tr(1);
    ck("rldrise", 14'h0005, 1'b0);
    u_src.tc(1);
    reloadEdge = RELOAD_FALL;
    u_src.tr(1);
    ck("rldfall", 14'h0005, 1'b0);
    u_src.err(1'b1, 1'b0);
    u_src.tc(1);
    ck("cnterr", 14'h0005, 1'b0);
    u_src.err(1'b0, 1'b1);
    u_src.tc(1);
    u_src.tr(2);
    ck("rlderr", 14'h0004, 1'b0);
    latchEn = 1'b1;
    u_src.err(1'b0, 1'b0);
    u_src.tc(1);
    ck("hit", 14'h0003, 1'b1);
    u_src.tc(1);
    ck("latch", 14'h0002, 1'b1);
    u_src.tr(2);
    ck("clear", 14'h0005, 1'b0);
    latchEn = 1'b0;
    targetValue = 14'h0005;
    u_src.tc(1);
    ck("tgt", 14'h0004, 1'b0);
    u_src.err(1'b1, 1'b0);
    u_src.tc(1);
    u_src.tr(2);
    ck("errrld", 14'h0005, 1'b1);
    u_src.err(1'b0, 1'b0);
    reset_n = 1'b0;
    loadValue = 14'h2710;
    targetValue = 14'h3FFF;
    ck("inrst", 14'h0000, 1'b0);
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b1;
    ck("powerup", COUNT_MAX, 1'b1);
    u_src.tc(1);
    ck("away", 14'h270E, 1'b0);
    conclude();
  end
endmodule
`default_nettype wire
